// ===== shared/dbsb_pkg.sv
// Purpose: Shared constants for the debug status and breakpoint block
// Assumes: Eight-bit status/control word, sixteen-bit breakpoint address
// Notes: Bit positions of the status/control word
package dbsb_pkg;
   // ****************************************
   // Widths
   // ****************************************
   localparam int ADDR_W = 16;
   localparam int BYTE_W = 8;
   // ****************************************
   // Status/control bit positions
   // ****************************************
   localparam int BIT_HALT_EN = 7;
   localparam int BIT_HALT_ACT = 6;
   localparam int BIT_BKPT_EN = 5;
   localparam int BIT_FTS = 4;
   localparam int BIT_CLK_SEL = 3;
   localparam int BIT_WS = 2;
   localparam int BIT_WSF = 1;
   localparam int BIT_DVF = 0;
   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] CTRL_RST_NORMAL = 8'h00;
   localparam logic [7:0] CTRL_RST_HALT = 8'hC8;
   localparam logic [15:0] BKPT_RST = 16'h0000;
   localparam logic [1:0] STRAP_WAIT = 2'h2;
   // ****************************************
   // Halt state
   // ****************************************
   typedef enum logic [0:0] {
      MODE_RUN = 1'b0,
      MODE_HALT = 1'b1
   } dbsb_mode_e;
endpackage

// ===== hw/dbsb_bkpt_cmp.sv
// Purpose: Sixteen-bit breakpoint address comparator
// Assumes: Address and valid from the CPU bus on mclk
// Notes: Match only while enabled
`timescale 1ns/100ps
module dbsb_bkpt_cmp (
   // Match setup
   input wire logic [15:0] match_addr,
   input wire logic enable,
   // CPU bus
   input wire logic [15:0] bus_addr,
   input wire logic bus_valid,
   // Result
   output logic hit
);
   always_comb begin
      hit = enable && bus_valid && (bus_addr == match_addr); // RQ19 RQ15
   end
endmodule

// ===== hw/dbsb_core.sv
// Purpose: Debug status/control flags and single hardware breakpoint
// Assumes: Serial engine delivers decoded command strobes on mclk
// Notes: Registers reachable only by serial debug commands
//
// What this block does
// RQ1: Tag mode: address match tags the fetched opcode; halt only if it executes.
// RQ2: Force mode: address match halts at next instruction boundary.
// RQ3: Clock select resets to 0 (alternate clock); 1 selects bus clock.
// RQ4: In wait/stop memory commands refused; force-halt still enters halt.
// RQ5: Host confirms halt-active flag is 1 after forcing halt.
// RQ6: Wait/stop status is 1 in wait/stop or halt forced out of it.
// RQ7: Wait/stop failure set when memory command collides with wait/stop.
// RQ8: Host recovers from wait/stop failure by force-halt and retry.
// RQ9: Data-valid failure set when memory command hits a slow access.
// RQ10: Match address is 16 bits: high byte 15..8, low byte 7..0.
// RQ11: Breakpoint enable and force/tag select configure the breakpoint.
// RQ12: Breakpoint address reachable only through serial breakpoint commands.
// RQ13: Breakpoint commands execute while the user program runs.
// RQ14: Host programs the breakpoint while in halt before starting.
// RQ15: Breakpoint enable 0 disables breakpoints, ignoring select and address.
// RQ16: Halt-active flag is 1 in halt, 0 while user code runs.
// RQ17: Debug-halt enable 0 blocks halt; non-intrusive commands still work.
// RQ18: Reset in halt sets enable, halt-active and clock select to 1.
// RQ19: Comparator checks full 16-bit address on each access while enabled.
`timescale 1ns/100ps
module dbsb_core (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Reset-in-halt strap pin
   input wire logic halt_strap_pin,
   // Serial command strobes
   input wire logic cmd_read_status,
   input wire logic cmd_write_control,
   input wire logic [7:0] cmd_wdata,
   input wire logic cmd_breakpoint_read_command,
   input wire logic cmd_breakpoint_write_command,
   input wire logic [15:0] cmd_bkpt_wdata,
   input wire logic cmd_background,
   input wire logic cmd_go,
   input wire logic cmd_mem_req,
   // Serial command answers
   output logic [15:0] cmd_rdata,
   output logic cmd_rvalid,
   output logic cmd_mem_refused,
   // Memory command outcome
   input wire logic mem_fail_wait_stop,
   input wire logic mem_fail_slow,
   // CPU bus and pipeline
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_access,
   input wire logic cpu_opcode_fetch,
   input wire logic cpu_insn_boundary,
   input wire logic cpu_exec_tagged,
   input wire logic cpu_wait_stop,
   // Outputs to CPU and serial engine
   output logic tag_opcode,
   output logic halt_active,
   output logic bus_clk_select
);
   // ****************************************
   // Strap synchroniser and reset-in-halt load
   // ****************************************
   logic strap_s1_ff, strap_s2_ff;
   logic [1:0] strap_cnt_ff, nxt_strap_cnt;
   logic strap_load;
   always_comb begin
      nxt_strap_cnt = strap_cnt_ff;
      if (strap_cnt_ff != dbsb_pkg::STRAP_WAIT + 2'h1) begin
         nxt_strap_cnt = strap_cnt_ff + 2'h1;
      end
      // One-shot load once the second flop holds the pin level
      strap_load = (strap_cnt_ff == dbsb_pkg::STRAP_WAIT) && strap_s2_ff;
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         strap_s1_ff <= 1'b0;
         strap_s2_ff <= 1'b0;
         strap_cnt_ff <= 2'h0;
      end else begin
         strap_s1_ff <= halt_strap_pin;
         strap_s2_ff <= strap_s1_ff;
         strap_cnt_ff <= nxt_strap_cnt;
      end
   end
   // ****************************************
   // Breakpoint comparator
   // ****************************************
   logic [7:0] bkpt_hi_ff, bkpt_lo_ff, nxt_bkpt_hi, nxt_bkpt_lo;
   logic halt_en_ff, bkpt_en_ff, fts_ff, clk_sel_ff;
   logic hit;
   dbsb_bkpt_cmp u_cmp (
      .match_addr({bkpt_hi_ff, bkpt_lo_ff}),
      .enable(bkpt_en_ff),
      .bus_addr(cpu_addr),
      .bus_valid(cpu_access),
      .hit(hit)
   );
   // ****************************************
   // Control, flags and halt state
   // ****************************************
   logic nxt_halt_en, nxt_bkpt_en, nxt_fts, nxt_clk_sel;
   logic ws_forced_ff, nxt_ws_forced, wsf_ff, nxt_wsf, dvf_ff, nxt_dvf;
   logic force_pend_ff, nxt_force_pend, tag_ff, nxt_tag;
   dbsb_pkg::dbsb_mode_e mode_ff, nxt_mode;
   logic enter_halt, ws_status;
   always_comb begin
      nxt_halt_en = halt_en_ff;
      nxt_bkpt_en = bkpt_en_ff;
      nxt_fts = fts_ff;
      nxt_clk_sel = clk_sel_ff;
      nxt_bkpt_hi = bkpt_hi_ff;
      nxt_bkpt_lo = bkpt_lo_ff;
      nxt_ws_forced = ws_forced_ff;
      nxt_wsf = wsf_ff;
      nxt_dvf = dvf_ff;
      nxt_force_pend = force_pend_ff;
      nxt_mode = mode_ff;
      nxt_tag = hit && !fts_ff && cpu_opcode_fetch; // RQ1 RQ11
      if (cmd_write_control) begin
         nxt_halt_en = cmd_wdata[dbsb_pkg::BIT_HALT_EN];
         nxt_bkpt_en = cmd_wdata[dbsb_pkg::BIT_BKPT_EN]; // RQ11
         nxt_fts = cmd_wdata[dbsb_pkg::BIT_FTS];
         nxt_clk_sel = cmd_wdata[dbsb_pkg::BIT_CLK_SEL]; // RQ3
      end
      if (cmd_breakpoint_write_command) begin
         nxt_bkpt_hi = cmd_bkpt_wdata[15:8]; // RQ10 RQ12 RQ13
         nxt_bkpt_lo = cmd_bkpt_wdata[7:0];
      end
      if (hit && fts_ff) begin
         nxt_force_pend = 1'b1; // RQ2
      end
      enter_halt = halt_en_ff && (mode_ff == dbsb_pkg::MODE_RUN) && (cmd_background
         || (force_pend_ff && cpu_insn_boundary) || cpu_exec_tagged); // RQ17 RQ1 RQ2 RQ4
      // Memory command outside wait/stop clears old failures; a failure on it wins
      if (cmd_mem_req && !cpu_wait_stop) begin
         nxt_wsf = 1'b0;
         nxt_dvf = 1'b0;
      end
      if (mem_fail_wait_stop) begin
         nxt_wsf = 1'b1; // RQ7
      end
      if (mem_fail_slow) begin
         nxt_dvf = 1'b1; // RQ9
      end
      if (enter_halt) begin
         nxt_mode = dbsb_pkg::MODE_HALT; // RQ16
         nxt_force_pend = 1'b0;
         nxt_ws_forced = cpu_wait_stop; // RQ6
      end else if (cmd_go && mode_ff == dbsb_pkg::MODE_HALT) begin
         nxt_mode = dbsb_pkg::MODE_RUN;
         nxt_ws_forced = 1'b0;
      end
      if (!bkpt_en_ff) begin
         nxt_force_pend = 1'b0; // RQ15
      end
      if (strap_load) begin
         nxt_halt_en = 1'b1; // RQ18
         nxt_clk_sel = 1'b1;
         nxt_mode = dbsb_pkg::MODE_HALT;
         nxt_bkpt_en = 1'b0;
         nxt_fts = 1'b0;
      end
      ws_status = cpu_wait_stop || ws_forced_ff; // RQ6
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         halt_en_ff <= dbsb_pkg::CTRL_RST_NORMAL[dbsb_pkg::BIT_HALT_EN];
         bkpt_en_ff <= dbsb_pkg::CTRL_RST_NORMAL[dbsb_pkg::BIT_BKPT_EN];
         fts_ff <= dbsb_pkg::CTRL_RST_NORMAL[dbsb_pkg::BIT_FTS];
         clk_sel_ff <= dbsb_pkg::CTRL_RST_NORMAL[dbsb_pkg::BIT_CLK_SEL]; // RQ3
         bkpt_hi_ff <= dbsb_pkg::BKPT_RST[15:8];
         bkpt_lo_ff <= dbsb_pkg::BKPT_RST[7:0];
         ws_forced_ff <= 1'b0;
         wsf_ff <= 1'b0;
         dvf_ff <= 1'b0;
         force_pend_ff <= 1'b0;
         tag_ff <= 1'b0;
         mode_ff <= dbsb_pkg::MODE_RUN;
      end else begin
         halt_en_ff <= nxt_halt_en;
         bkpt_en_ff <= nxt_bkpt_en;
         fts_ff <= nxt_fts;
         clk_sel_ff <= nxt_clk_sel;
         bkpt_hi_ff <= nxt_bkpt_hi;
         bkpt_lo_ff <= nxt_bkpt_lo;
         ws_forced_ff <= nxt_ws_forced;
         wsf_ff <= nxt_wsf;
         dvf_ff <= nxt_dvf;
         force_pend_ff <= nxt_force_pend;
         tag_ff <= nxt_tag;
         mode_ff <= nxt_mode;
      end
   end
   // ****************************************
   // Command answers
   // ****************************************
   logic [15:0] rdata_ff, nxt_rdata;
   logic rvalid_ff, nxt_rvalid;
   logic [7:0] status_byte;
   always_comb begin
      status_byte = {halt_en_ff, (mode_ff == dbsb_pkg::MODE_HALT), bkpt_en_ff, fts_ff,
         clk_sel_ff, ws_status, wsf_ff, dvf_ff};
      nxt_rdata = rdata_ff;
      nxt_rvalid = cmd_read_status || cmd_breakpoint_read_command;
      if (cmd_read_status) begin
         nxt_rdata = {8'h00, status_byte};
      end else if (cmd_breakpoint_read_command) begin
         nxt_rdata = {bkpt_hi_ff, bkpt_lo_ff}; // RQ10 RQ13
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= 16'h0000;
         rvalid_ff <= 1'b0;
      end else begin
         rdata_ff <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
      end
   end
   assign cmd_rdata = rdata_ff;
   assign cmd_rvalid = rvalid_ff;
   assign cmd_mem_refused = cmd_mem_req && cpu_wait_stop; // RQ4
   assign tag_opcode = tag_ff;
   assign halt_active = (mode_ff == dbsb_pkg::MODE_HALT);
   assign bus_clk_select = clk_sel_ff;
   // ****************************************
   // Assertions
   // ****************************************
   sequence force_hit_s;
      hit && fts_ff && halt_en_ff && !halt_active;
   endsequence
   sequence boundary_s;
      cpu_insn_boundary && !strap_load;
   endsequence
   force_halt_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ2
      force_hit_s ##1 (!cpu_insn_boundary && !halt_active && bkpt_en_ff)
      ##1 (boundary_s and (bkpt_en_ff && halt_en_ff && !halt_active)) |=> halt_active)
      else $error("force breakpoint did not halt");
   tag_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ1
      (hit && !fts_ff && cpu_opcode_fetch) |=> tag_opcode)
      else $error("tag not raised on fetch match");
   tag_nohalt_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ1
      (!halt_active && !cmd_background && !cpu_exec_tagged && !force_pend_ff && !strap_load)
      |=> !halt_active)
      else $error("halt without cause");
   clk_sel_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ3
      (cmd_write_control && !strap_load) |=>
      bus_clk_select == $past(cmd_wdata[dbsb_pkg::BIT_CLK_SEL]))
      else $error("clock select not written");
   bg_wait_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ4
      (cmd_background && cpu_wait_stop && halt_en_ff && !halt_active) |=> halt_active
      ##0 status_byte[dbsb_pkg::BIT_WS])
      else $error("force halt from wait failed");
   ws_read_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ6
      cpu_wait_stop |-> status_byte[dbsb_pkg::BIT_WS])
      else $error("wait status low in wait");
   wsf_set_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ7
      mem_fail_wait_stop |=> status_byte[dbsb_pkg::BIT_WSF])
      else $error("wait failure not set");
   dvf_set_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ9
      mem_fail_slow |=> status_byte[dbsb_pkg::BIT_DVF])
      else $error("data valid failure not set");
   bkpt_rw_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ10
      cmd_breakpoint_write_command ##1 !cmd_breakpoint_write_command
      ##1 (cmd_breakpoint_read_command && !cmd_breakpoint_write_command && !cmd_read_status) |=>
      cmd_rvalid && cmd_rdata == $past(cmd_bkpt_wdata, 3))
      else $error("breakpoint readback wrong");
   bkpt_off_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ15
      !bkpt_en_ff |-> !hit ##1 !tag_opcode)
      else $error("match while disabled");
   halt_block_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ17
      (!halt_en_ff && !halt_active && !strap_load) |=> !halt_active)
      else $error("halt while disabled");
endmodule

// ===== test/dbsb_host_model.sv
// Purpose: Debug host model issuing serial command strobes
// Assumes: Strobes change at falling mclk, one cycle wide
// Notes: Read answers captured one cycle after the strobe
`timescale 1ns/100ps
module dbsb_host_model (
   // Clock
   input wire logic mclk,
   // Command strobes
   output logic cmd_read_status,
   output logic cmd_write_control,
   output logic [7:0] cmd_wdata,
   output logic cmd_breakpoint_read_command,
   output logic cmd_breakpoint_write_command,
   output logic [15:0] cmd_bkpt_wdata,
   output logic cmd_background,
   output logic cmd_go,
   output logic cmd_mem_req,
   // Answers
   input wire logic [15:0] cmd_rdata,
   input wire logic cmd_rvalid,
   input wire logic cmd_mem_refused
);
   logic [15:0] rd_data;
   logic rd_ok;
   logic refused_seen;
   initial begin
      {cmd_read_status, cmd_write_control, cmd_breakpoint_read_command, cmd_breakpoint_write_command} = 4'h0;
      {cmd_background, cmd_go, cmd_mem_req} = 3'h0;
      cmd_wdata = 8'h00;
      cmd_bkpt_wdata = 16'h0000;
   end
   // ****************************************
   // One command: 0 status, 1 ctrl, 2 rd bkpt, 3 wr bkpt, 4 bgnd, 5 go, 6 mem
   // ****************************************
   task automatic issue(input int kind, input logic [15:0] data);
      @(negedge mclk);
      case (kind)
         0: cmd_read_status = 1'b1;
         1: begin
            cmd_write_control = 1'b1;
            cmd_wdata = data[7:0];
         end
         2: cmd_breakpoint_read_command = 1'b1;
         3: begin
            cmd_breakpoint_write_command = 1'b1;
            cmd_bkpt_wdata = data;
         end
         4: cmd_background = 1'b1;
         5: cmd_go = 1'b1;
         default: cmd_mem_req = 1'b1;
      endcase
      #1;
      refused_seen = cmd_mem_refused;
      @(negedge mclk);
      // Answer stands only until the next rising edge
      if (kind == 0 || kind == 2) begin
         rd_ok = cmd_rvalid;
         rd_data = cmd_rdata;
      end
      {cmd_read_status, cmd_write_control, cmd_breakpoint_read_command, cmd_breakpoint_write_command} = 4'h0;
      {cmd_background, cmd_go, cmd_mem_req} = 3'h0;
      cmd_wdata = ~cmd_wdata;
      cmd_bkpt_wdata = ~cmd_bkpt_wdata;
   endtask
endmodule

// ===== test/debug_status_and_breakpoint_bench.sv
// Purpose: Self-checking bench for the debug status and breakpoint core
// Assumes: Inputs change at falling mclk
// Notes: Random breakpoint addresses from a fixed seed
`timescale 1ns/100ps
module debug_status_and_breakpoint_bench;
   logic mclk, rst_n, strap, rvalid, refused, mfail_ws, mfail_slow;
   logic rs, wc, rb, wb, bg, go, mreq, tag, hact, clk_sel;
   logic access, fetch, bound, exec, wstop;
   logic [7:0] wdata;
   logic [15:0] bdata, rdata, addr, bp;
   int err_count = 0;
   int samples_checked = 0;
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   dbsb_host_model host (.mclk(mclk), .cmd_read_status(rs), .cmd_write_control(wc),
      .cmd_wdata(wdata), .cmd_breakpoint_read_command(rb), .cmd_breakpoint_write_command(wb), .cmd_bkpt_wdata(bdata),
      .cmd_background(bg), .cmd_go(go), .cmd_mem_req(mreq), .cmd_rdata(rdata),
      .cmd_rvalid(rvalid), .cmd_mem_refused(refused));
   dbsb_core DUT (.mclk(mclk), .rst_n(rst_n), .halt_strap_pin(strap),
      .cmd_read_status(rs), .cmd_write_control(wc), .cmd_wdata(wdata),
      .cmd_breakpoint_read_command(rb), .cmd_breakpoint_write_command(wb), .cmd_bkpt_wdata(bdata),
      .cmd_background(bg), .cmd_go(go), .cmd_mem_req(mreq), .cmd_rdata(rdata),
      .cmd_rvalid(rvalid), .cmd_mem_refused(refused), .mem_fail_wait_stop(mfail_ws),
      .mem_fail_slow(mfail_slow), .cpu_addr(addr), .cpu_access(access),
      .cpu_opcode_fetch(fetch), .cpu_insn_boundary(bound), .cpu_exec_tagged(exec),
      .cpu_wait_stop(wstop), .tag_opcode(tag), .halt_active(hact), .bus_clk_select(clk_sel));
   // ****************************************
   // Helpers
   // ****************************************
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
      samples_checked++;
      if (got !== exp) begin
         $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
         err_count++;
      end
   endtask
   task automatic cpu(input logic [15:0] a, input logic [4:0] sig);
      @(negedge mclk);
      addr = a;
      {access, fetch, bound, exec, mfail_ws} = sig;
      @(negedge mclk);
      {access, fetch, bound, exec, mfail_ws} = 5'h00;
      addr = ~a;
   endtask
   task automatic expect_halt(input logic exp);
      int n;
      for (n = 0; n < 4 && hact !== exp; n++) @(negedge mclk);
      check({15'h0000, hact}, {15'h0000, exp}, "halt state");
      if (hact !== exp) complete_run();
   endtask
   function automatic logic [15:0] status(input logic [7:0] b);
      return {8'h00, b};
   endfunction
   task automatic rd_status(input logic [7:0] mask, input logic [7:0] exp, input string msg);
      host.issue(0, 16'h0000);
      check({15'h0000, host.rd_ok}, 16'h0001, "read answer");
      check(host.rd_data & status(mask), status(exp), msg);
   endtask
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      {rst_n, strap, mfail_ws, mfail_slow, access, fetch, bound, exec, wstop} = 9'h000;
      addr = 16'h0000;
      void'($urandom(94666));
      repeat (3) @(negedge mclk);
      rst_n = 1'b1;
      repeat (3) @(negedge mclk);
      check({15'h0000, clk_sel}, 16'h0000, "clock select reset");
      rd_status(8'hFF, 8'h00, "status reset");
      repeat (3) begin
         bp = 16'($urandom());
         host.issue(3, bp);
         host.issue(2, 16'h0000);
         check(host.rd_data, bp, "breakpoint readback");
      end
      $display("test register access done");
      host.issue(1, 16'h0088);
      check({15'h0000, clk_sel}, 16'h0001, "clock select set");
      host.issue(1, 16'h00B0);
      cpu(bp ^ 16'h8000, 5'h14);
      expect_halt(1'b0);
      cpu(bp, 5'h10);
      cpu(~bp, 5'h04);
      expect_halt(1'b1);
      rd_status(8'hF0, 8'hF0, "force halt status");
      host.issue(5, 16'h0000);
      expect_halt(1'b0);
      host.issue(1, 16'h00A0);
      cpu(bp, 5'h18);
      check({15'h0000, tag}, 16'h0001, "tag pulse");
      check({15'h0000, hact}, 16'h0000, "no halt before execute");
      cpu(~bp, 5'h02);
      expect_halt(1'b1);
      host.issue(5, 16'h0000);
      host.issue(1, 16'h0090);
      cpu(bp, 5'h1C);
      check({15'h0000, tag}, 16'h0000, "tag while disabled");
      expect_halt(1'b0);
      host.issue(1, 16'h0000);
      host.issue(4, 16'h0000);
      expect_halt(1'b0);
      $display("test breakpoint modes done");
      host.issue(1, 16'h0080);
      wstop = 1'b1;
      host.issue(6, 16'h0000);
      check({15'h0000, host.refused_seen}, 16'h0001, "mem refused");
      rd_status(8'h04, 8'h04, "wait stop status");
      host.issue(4, 16'h0000);
      expect_halt(1'b1);
      rd_status(8'hC4, 8'hC4, "halt from wait");
      wstop = 1'b0;
      host.issue(6, 16'h0000);
      check({15'h0000, host.refused_seen}, 16'h0000, "mem accepted");
      mfail_slow = 1'b1;
      cpu(bp, 5'h01);
      mfail_slow = 1'b0;
      rd_status(8'h03, 8'h03, "failure flags");
      host.issue(6, 16'h0000);
      rd_status(8'h03, 8'h00, "flags cleared");
      host.issue(5, 16'h0000);
      $display("test wait stop done");
      strap = 1'b1;
      @(negedge mclk);
      rst_n = 1'b0;
      @(negedge mclk);
      rst_n = 1'b1;
      repeat (3) @(negedge mclk);
      check({15'h0000, hact}, 16'h0001, "halt after strap reset");
      rd_status(8'hFF, 8'hC8, "strap reset status");
      $display("test reset in halt done");
      complete_run();
   end
endmodule
